// [hw/dtc_consts.vh]
// register map, field positions and timing constants of the dual timer/counter unit
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH
`define DTC_ADDR_CTRL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_T0LO 8'h8a
`define DTC_ADDR_T1LO 8'h8b
`define DTC_ADDR_T0HI 8'h8c
`define DTC_ADDR_T1HI 8'h8d
`define DTC_CTRL_TF1 7
`define DTC_CTRL_TR1 6
`define DTC_CTRL_TF0 5
`define DTC_CTRL_TR0 4
`define DTC_CTRL_IE1 3
`define DTC_CTRL_IT1 2
`define DTC_CTRL_IE0 1
`define DTC_CTRL_IT0 0
`define DTC_MODE_GATE0 7
`define DTC_MODE_CT0 6
`define DTC_MODE_M0_HI 5
`define DTC_MODE_M0_LO 4
`define DTC_MODE_GATE1 3
`define DTC_MODE_CT1 2
`define DTC_MODE_M1_HI 1
`define DTC_MODE_M1_LO 0
`define DTC_MODE_13BIT 2'b00
`define DTC_MODE_16BIT 2'b01
`define DTC_MODE_RELOAD 2'b10
`define DTC_MODE_SPLIT 2'b11
`define DTC_CTRL_RESET 8'h00
`define DTC_MODE_RESET 8'h00
`define DTC_CLKS_PER_MCYCLE 12
`define DTC_EDGE_MCYCLES 2
`endif

// [hw/dtc_sync.v]
// three-stage synchroniser with agreement filter for an external level
`timescale 1ns/10ps
module dtc_sync
(
  input wire clk_sys,
  input wire rst_n,
  input wire pin_in,
  output reg level_q
);
  reg [2:0] stage_q;
  // stage_q[0] only feeds stage_q[1]; a change counts once stages 1 and 2 agree
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      stage_q <= 3'h7;
      level_q <= 1'b1;
    end
    else
    begin
      stage_q <= {stage_q[1:0], pin_in};
      if (stage_q[1] == stage_q[2])
        level_q <= stage_q[2];
    end
  end
endmodule // dtc_sync

// [hw/dtc_edge.v]
// falling-edge detector sampled once per machine cycle
`timescale 1ns/10ps
module dtc_edge
(
  input wire clk_sys,
  input wire rst_n,
  input wire sample_en,
  input wire level,
  output reg fall_q
);
  reg last_q;
  // two machine-cycle samples, high then low, make one edge; caps count rate
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      last_q <= 1'b1;
      fall_q <= 1'b0;
    end
    else
    begin
      fall_q <= 1'b0;
      if (sample_en)
      begin
        last_q <= level;
        fall_q <= last_q & ~level;
      end
    end
  end
endmodule // dtc_edge

// [hw/dtc_timer_unit.v]
// dual timer/counter unit on the processor special function register bus
// Functional notes
// - mode 2 reloads low byte from high byte on low-byte overflow.
// - reload mode timer advances low byte once per machine cycle while running.
// - timer 1 in mode 3 stops and holds its value.
// - timer 0 in mode 3 becomes two independent 8-bit counters.
// - split low byte uses timer 0 run and gate, sets timer 0 flag.
// - split high byte uses timer 1 run, sets timer 1 flag.
// - gate plus run counts falling edges of the routed input signal.
// - counter-select 1 counts events, 0 counts machine cycles; bits 6 and 2.
// - mode fields at bits 5:4 and 1:0, gate bits 7 and 3.
// - timer 1 flag set on overflow, cleared by software or acknowledge.
// - timer 0 flag set on overflow, cleared by software or acknowledge.
// - run bits at control bits 6 and 4; clearing stops the timer.
// - edge flags set on falling interrupt input, cleared on acknowledge.
// - type bits choose edge or low-level interrupt sensitivity.
// - type bit 0 means low level, 1 means falling edge.
// - timer operation advances once per twelve processor clocks.
// - mode 0 is 13-bit with low byte upper three bits zero; mode 1 16-bit.
// - counter input edges need two machine cycles to be recognised.
`timescale 1ns/10ps
`include "dtc_consts.vh"
module dtc_timer_unit
#(
  parameter CLKS_PER_MCYCLE = `DTC_CLKS_PER_MCYCLE
)
(
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata_q,
  output reg sfr_hit_q,
  input wire count_in0,
  input wire count_in1,
  input wire ext_irq0_n,
  input wire ext_irq1_n,
  input wire timer0_ack,
  input wire timer1_ack,
  input wire ext_irq0_ack,
  input wire ext_irq1_ack,
  output reg timer0_irq_q,
  output reg timer1_irq_q,
  output reg ext_irq0_req_q,
  output reg ext_irq1_req_q
);
  reg [7:0] ctrl_q;
  reg [7:0] mode_q;
  // count bytes, low and high half of each timer
  reg [7:0] t0lo_q;
  reg [7:0] t0hi_q;
  reg [7:0] t1lo_q;
  reg [7:0] t1hi_q;
  reg [3:0] pre_q;
  reg mcyc_q;
  // four-bit prescaler: a machine cycle longer than sixteen clocks needs a wider pre_q
  localparam [31:0] PRE_LAST_W = CLKS_PER_MCYCLE - 1;
  wire [3:0] pre_last = PRE_LAST_W[3:0];
  wire [3:0] pins_lvl;
  wire [3:0] pins_fall;
  // inputs idle high; synchronisers reset to one, so release makes no false edge
  wire [3:0] pins_raw = {ext_irq1_n, ext_irq0_n, count_in1, count_in0};
  genvar gi;
  // one synchroniser and edge detector per external input
  // count and interrupt pins share one path, so counting and edge-mode interrupts see the same latency
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_pin
      dtc_sync u_sync
      (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in(pins_raw[gi]),
        .level_q(pins_lvl[gi])
      );
      dtc_edge u_edge
      (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sample_en(mcyc_q),
        .level(pins_lvl[gi]),
        .fall_q(pins_fall[gi])
      );
    end
  endgenerate
  // machine-cycle strobe
  // high one clock in every CLKS_PER_MCYCLE, first a full period after reset
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pre_q <= 4'h0;
      mcyc_q <= 1'b0;
    end
    else
    begin
      mcyc_q <= (pre_q == pre_last);
      pre_q <= (pre_q == pre_last) ? 4'h0 : pre_q + 4'h1;
    end
  end
  wire [1:0] m0 = mode_q[`DTC_MODE_M0_HI:`DTC_MODE_M0_LO];
  wire [1:0] m1 = mode_q[`DTC_MODE_M1_HI:`DTC_MODE_M1_LO];
  wire run0 = ctrl_q[`DTC_CTRL_TR0];
  wire run1 = ctrl_q[`DTC_CTRL_TR1];
  // gate with run: count routed-input falling edges
  wire tick0 = mode_q[`DTC_MODE_GATE0] | mode_q[`DTC_MODE_CT0] ? pins_fall[0] : mcyc_q;
  wire tick1 = mode_q[`DTC_MODE_GATE1] | mode_q[`DTC_MODE_CT1] ? pins_fall[1] : mcyc_q;
  wire en0 = run0 & tick0;
  // split mode high byte clocks on machine cycles under timer 1 run
  wire en0h = (m0 == `DTC_MODE_SPLIT) & run1 & mcyc_q;
  // timer 1 in mode 3 holds its count; its run bit still clocks a split high byte
  wire en1 = run1 & tick1 & (m1 != `DTC_MODE_SPLIT);
  reg [7:0] t0lo_d, t0hi_d, t1lo_d, t1hi_d;
  // overflow pulses, taken by the flag logic on the same edge
  reg ovf0, ovf1;
  always @*
  begin
    t0lo_d = t0lo_q;
    t0hi_d = t0hi_q;
    t1lo_d = t1lo_q;
    t1hi_d = t1hi_q;
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    // mode 0 keeps the top three low-byte bits clear, counting or not
    if (m0 == `DTC_MODE_13BIT)
      t0lo_d = {3'h0, t0lo_q[4:0]};
    if (m1 == `DTC_MODE_13BIT)
      t1lo_d = {3'h0, t1lo_q[4:0]};
    if (en0)
    begin
      case (m0)
        `DTC_MODE_13BIT:
        begin
          // five-bit prescale carries into the high byte
          t0lo_d = {3'h0, t0lo_q[4:0] + 5'h01};
          if (t0lo_q[4:0] == 5'h1f)
          begin
            t0hi_d = t0hi_q + 8'h01;
            ovf0 = (t0hi_q == 8'hff);
          end
        end
        `DTC_MODE_16BIT:
        begin
          t0lo_d = t0lo_q + 8'h01;
          if (t0lo_q == 8'hff)
          begin
            t0hi_d = t0hi_q + 8'h01;
            ovf0 = (t0hi_q == 8'hff);
          end
        end
        `DTC_MODE_RELOAD:
        begin
          // reload takes the high byte as it stood before this edge
          t0lo_d = (t0lo_q == 8'hff) ? t0hi_q : t0lo_q + 8'h01;
          ovf0 = (t0lo_q == 8'hff);
        end
        default:
        begin
          // split low byte runs alone under run 0 and gate 0
          t0lo_d = t0lo_q + 8'h01;
          ovf0 = (t0lo_q == 8'hff);
        end
      endcase
    end
    if (en0h)
    begin
      t0hi_d = t0hi_q + 8'h01;
      ovf1 = (t0hi_q == 8'hff);
    end
    if (en1)
    begin
      case (m1)
        `DTC_MODE_13BIT:
        begin
          t1lo_d = {3'h0, t1lo_q[4:0] + 5'h01};
          if (t1lo_q[4:0] == 5'h1f)
          begin
            t1hi_d = t1hi_q + 8'h01;
            ovf1 = ovf1 | (t1hi_q == 8'hff);
          end
        end
        `DTC_MODE_16BIT:
        begin
          t1lo_d = t1lo_q + 8'h01;
          if (t1lo_q == 8'hff)
          begin
            t1hi_d = t1hi_q + 8'h01;
            ovf1 = ovf1 | (t1hi_q == 8'hff);
          end
        end
        default:
        begin
          t1lo_d = (t1lo_q == 8'hff) ? t1hi_q : t1lo_q + 8'h01;
          // split timer 0 owns timer 1 flag; timer 1 reload overflow then sets no flag
          ovf1 = ovf1 | ((t1lo_q == 8'hff) & (m0 != `DTC_MODE_SPLIT));
        end
      endcase
    end
  end
  wire wr_ctrl = sfr_wr & (sfr_addr == `DTC_ADDR_CTRL);
  // one decode per register
  wire wr_mode = sfr_wr & (sfr_addr == `DTC_ADDR_MODE);
  wire wr_t0lo = sfr_wr & (sfr_addr == `DTC_ADDR_T0LO);
  wire wr_t0hi = sfr_wr & (sfr_addr == `DTC_ADDR_T0HI);
  wire wr_t1lo = sfr_wr & (sfr_addr == `DTC_ADDR_T1LO);
  wire wr_t1hi = sfr_wr & (sfr_addr == `DTC_ADDR_T1HI);
  // a mode 0 write lands with the top three low-byte bits already clear
  wire [7:0] t0lo_wdata = (m0 == `DTC_MODE_13BIT) ? {3'h0, sfr_wdata[4:0]} : sfr_wdata;
  wire [7:0] t1lo_wdata = (m1 == `DTC_MODE_13BIT) ? {3'h0, sfr_wdata[4:0]} : sfr_wdata;
  // external interrupt conditions
  // edge mode sees a fall sampled once per machine cycle
  wire irq0_set = ctrl_q[`DTC_CTRL_IT0] ? pins_fall[2] : 1'b0;
  wire irq1_set = ctrl_q[`DTC_CTRL_IT1] ? pins_fall[3] : 1'b0;
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctrl_q <= `DTC_CTRL_RESET;
      mode_q <= `DTC_MODE_RESET;
      t0lo_q <= 8'h00;
      t0hi_q <= 8'h00;
      t1lo_q <= 8'h00;
      t1hi_q <= 8'h00;
    end
    else
    begin
      // software writes win over counting on the same edge
      t0lo_q <= wr_t0lo ? t0lo_wdata : t0lo_d;
      t0hi_q <= wr_t0hi ? sfr_wdata : t0hi_d;
      t1lo_q <= wr_t1lo ? t1lo_wdata : t1lo_d;
      t1hi_q <= wr_t1hi ? sfr_wdata : t1hi_d;
      // new mode applies from the next edge; counts are kept as they stand
      if (wr_mode)
        mode_q <= sfr_wdata;
      // written ones never set a flag, so read-modify-write cannot raise one
      if (wr_ctrl)
      begin
        ctrl_q[`DTC_CTRL_TR1] <= sfr_wdata[`DTC_CTRL_TR1];
        ctrl_q[`DTC_CTRL_TR0] <= sfr_wdata[`DTC_CTRL_TR0];
        ctrl_q[`DTC_CTRL_IT1] <= sfr_wdata[`DTC_CTRL_IT1];
        ctrl_q[`DTC_CTRL_IT0] <= sfr_wdata[`DTC_CTRL_IT0];
      end
      // set wins over software write and acknowledge
      ctrl_q[`DTC_CTRL_TF1] <= ovf1 | (ctrl_q[`DTC_CTRL_TF1] & ~timer1_ack
        & ~(wr_ctrl & ~sfr_wdata[`DTC_CTRL_TF1]));
      ctrl_q[`DTC_CTRL_TF0] <= ovf0 | (ctrl_q[`DTC_CTRL_TF0] & ~timer0_ack
        & ~(wr_ctrl & ~sfr_wdata[`DTC_CTRL_TF0]));
      // level mode: flag mirrors the synchronised low level, no latching
      // acknowledge and writes leave a level-mode flag alone; only the pin clears it
      if (!ctrl_q[`DTC_CTRL_IT1])
        ctrl_q[`DTC_CTRL_IE1] <= ~pins_lvl[3];
      else
        ctrl_q[`DTC_CTRL_IE1] <= irq1_set | (ctrl_q[`DTC_CTRL_IE1] & ~ext_irq1_ack
          & ~(wr_ctrl & ~sfr_wdata[`DTC_CTRL_IE1]));
      if (!ctrl_q[`DTC_CTRL_IT0])
        ctrl_q[`DTC_CTRL_IE0] <= ~pins_lvl[2];
      else
        ctrl_q[`DTC_CTRL_IE0] <= irq0_set | (ctrl_q[`DTC_CTRL_IE0] & ~ext_irq0_ack
          & ~(wr_ctrl & ~sfr_wdata[`DTC_CTRL_IE0]));
    end
  end
  // registered read port and request outputs
  // a 16-bit count is read a byte at a time; software re-reads if the low byte wrapped
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sfr_rdata_q <= 8'h00;
      sfr_hit_q <= 1'b0;
      timer0_irq_q <= 1'b0;
      timer1_irq_q <= 1'b0;
      ext_irq0_req_q <= 1'b0;
      ext_irq1_req_q <= 1'b0;
    end
    else
    begin
      // requests trail the flags by one clock
      timer0_irq_q <= ctrl_q[`DTC_CTRL_TF0];
      timer1_irq_q <= ctrl_q[`DTC_CTRL_TF1];
      ext_irq0_req_q <= ctrl_q[`DTC_CTRL_IE0];
      ext_irq1_req_q <= ctrl_q[`DTC_CTRL_IE1];
      sfr_hit_q <= 1'b0;
      sfr_rdata_q <= 8'h00;
      if (sfr_rd)
      begin
        sfr_hit_q <= 1'b1;
        case (sfr_addr)
          `DTC_ADDR_CTRL: sfr_rdata_q <= ctrl_q;
          `DTC_ADDR_MODE: sfr_rdata_q <= mode_q;
          `DTC_ADDR_T0LO: sfr_rdata_q <= t0lo_q;
          `DTC_ADDR_T1LO: sfr_rdata_q <= t1lo_q;
          `DTC_ADDR_T0HI: sfr_rdata_q <= t0hi_q;
          `DTC_ADDR_T1HI: sfr_rdata_q <= t1hi_q;
          default: sfr_hit_q <= 1'b0;
        endcase
      end
    end
  end
endmodule // dtc_timer_unit

// [tb/dtc_sfr_host.sv]
// processor-side register bus model issuing one-cycle strobes
`timescale 1ns/10ps
module dtc_sfr_host
(
  input wire clk_sys,
  output reg [7:0] sfr_addr,
  output reg [7:0] sfr_wdata,
  output reg sfr_wr,
  output reg sfr_rd,
  input wire [7:0] sfr_rdata_q,
  input wire sfr_hit_q
);
  initial
  begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  end
  // released bus shows the inverse, never a stale value
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk_sys);
      sfr_addr <= a;
      sfr_wdata <= v;
      sfr_wr <= 1'b1;
      @(posedge clk_sys);
      sfr_wr <= 1'b0;
      sfr_addr <= ~a;
      sfr_wdata <= ~v;
    end
  endtask
  // data stands one cycle only, so taken mid-cycle after the answering edge
  task rd(input [7:0] a, output [7:0] v, output h);
    begin
      @(posedge clk_sys);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk_sys);
      sfr_rd <= 1'b0;
      sfr_addr <= ~a;
      @(negedge clk_sys);
      v = sfr_rdata_q;
      h = sfr_hit_q;
    end
  endtask
endmodule // dtc_sfr_host

// [tb/dtc_timer_unit_asserts.sv]
// assertions on the register bus and overflow flags of the timer unit
`timescale 1ns/10ps
module dtc_chk
(
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_rdata_q,
  input wire sfr_hit_q,
  input wire timer0_ack,
  input wire timer1_ack,
  input wire timer0_irq_q,
  input wire timer1_irq_q
);
  // shadow of run and type bits, the flags are left out
  reg [7:0] ctl_q;
  wire mapped = sfr_addr >= 8'h88 && sfr_addr <= 8'h8d;
  always @(posedge clk_sys)
  begin
    if (!rst_n)
      ctl_q <= 8'h00;
    else if (sfr_wr && sfr_addr == 8'h88)
      ctl_q <= sfr_wdata & 8'h55;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  rd_idle_a: assert property (!sfr_rd |=> sfr_rdata_q == 8'h00 && !sfr_hit_q)
    else $error("read data without read");
  rd_unmapped_a: assert property (sfr_rd && !mapped |=> sfr_rdata_q == 8'h00 && !sfr_hit_q)
    else $error("unmapped read answered");
  rd_hit_a: assert property (sfr_rd && mapped |=> sfr_hit_q)
    else $error("mapped read not answered");
  ctrl_rdback_a: assert property (sfr_rd && !sfr_wr && sfr_addr == 8'h88 |=> (sfr_rdata_q & 8'h55) == ctl_q)
    else $error("control bits read back wrong");
  t0_ack_clr_a: assert property (timer0_ack && !ctl_q[4] && !sfr_wr |=> ##1 !timer0_irq_q)
    else $error("timer0 flag survives ack");
  t1_ack_clr_a: assert property (timer1_ack && !ctl_q[6] && !sfr_wr |=> ##1 !timer1_irq_q)
    else $error("timer1 flag survives ack");
  t0_run_src_a: assert property ($rose(timer0_irq_q) |-> $past(ctl_q[4]))
    else $error("timer0 overflow while stopped");
  t1_run_src_a: assert property ($rose(timer1_irq_q) |-> $past(ctl_q[6]))
    else $error("timer1 overflow while stopped");
endmodule // dtc_chk
bind dtc_timer_unit dtc_chk u_chk (.clk_sys, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
  .sfr_rdata_q, .sfr_hit_q, .timer0_ack, .timer1_ack, .timer0_irq_q, .timer1_irq_q);

// [tb/tb_dual_timer_counter_unit.sv]
// self-checking bench for the dual timer/counter unit
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin err_total++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_dual_timer_counter_unit;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg [1:0] cin = 2'b11;
  reg [1:0] eirq_n = 2'b11;
  reg [1:0] tack = 2'b00;
  reg [1:0] eack = 2'b00;
  wire [7:0] sfr_addr, sfr_wdata, sfr_rdata_q;
  wire sfr_wr, sfr_rd, sfr_hit_q;
  wire [1:0] tirq, ereq;
  reg [7:0] d;
  reg hit;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int i;
  // write address, data, read address, expected data
  reg [31:0] rows [0:9] = '{32'h89a589a5, 32'h8a3c8a3c, 32'h8bc38bc3, 32'h8c5a8c5a, 32'h8da58da5,
    32'h88058805, 32'h90ff9000, 32'h89008900, 32'h8aff8a1f, 32'h88008800};
  always #25 clk_sys = ~clk_sys;
  dtc_sfr_host h (.clk_sys, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata_q, .sfr_hit_q);
  dtc_timer_unit DUT (.clk_sys, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata_q,
    .sfr_hit_q, .count_in0(cin[0]), .count_in1(cin[1]), .ext_irq0_n(eirq_n[0]),
    .ext_irq1_n(eirq_n[1]), .timer0_ack(tack[0]), .timer1_ack(tack[1]), .ext_irq0_ack(eack[0]),
    .ext_irq1_ack(eack[1]), .timer0_irq_q(tirq[0]), .timer1_irq_q(tirq[1]),
    .ext_irq0_req_q(ereq[0]), .ext_irq1_req_q(ereq[1]));
  task final_report;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // two increments to overflow, stop, read one byte, then acknowledge
  task ovf(input [7:0] md, ra, lo, rb, hi, run, ea, ee, input sel);
    int n;
    begin
      n = 0;
      h.wr(8'h89, md);
      h.wr(ra, lo);
      h.wr(rb, hi);
      h.wr(8'h88, run);
      while (tirq[sel] !== 1'b1 && n < 40)
      begin
        @(negedge clk_sys);
        n++;
      end
      `CHK("overflow time", 1'b1, n >= 15 && n <= 26)
      h.wr(8'h88, 8'ha0);
      h.rd(ea, d, hit);
      `CHK("count byte", ee, d)
      @(posedge clk_sys) tack[sel] <= 1'b1;
      @(posedge clk_sys) tack <= 2'b00;
      repeat (2) @(negedge clk_sys);
      `CHK("flag after ack", 1'b0, tirq[sel])
      $display("overflow test mode %h done", md);
    end
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    // run needs about 900 cycles
    if (cyc == 20000)
    begin
      err_total++;
      final_report;
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 10; i++)
    begin
      h.wr(rows[i][31:24], rows[i][23:16]);
      h.rd(rows[i][15:8], d, hit);
      `CHK("row data", rows[i][7:0], d)
      `CHK("row hit", rows[i][15:8] inside {[8'h88:8'h8d]}, hit)
    end
    $display("register rows done");
    ovf(8'h10, 8'h8a, 8'hfe, 8'h8c, 8'hff, 8'h10, 8'h8c, 8'h00, 1'b0);
    ovf(8'h00, 8'h8b, 8'h1e, 8'h8d, 8'hff, 8'h40, 8'h8b, 8'h00, 1'b1);
    // both in reload mode, never reload beside 13 or 16 bit
    ovf(8'h22, 8'h8a, 8'hfe, 8'h8c, 8'hf0, 8'h10, 8'h8a, 8'hf0, 1'b0);
    ovf(8'h22, 8'h8b, 8'hfe, 8'h8d, 8'h33, 8'h40, 8'h8b, 8'h33, 1'b1);
    ovf(8'h33, 8'h8a, 8'hfe, 8'h8b, 8'h77, 8'h50, 8'h8b, 8'h77, 1'b0);
    ovf(8'h33, 8'h8c, 8'hfe, 8'h8d, 8'h55, 8'h40, 8'h8d, 8'h55, 1'b1);
    // gate, then counter select; levels held three machine cycles
    for (i = 0; i < 2; i++)
    begin
      h.wr(8'h89, i ? 8'h05 : 8'h09);
      h.wr(8'h8b, 8'h00);
      h.wr(8'h88, 8'h40);
      repeat (3)
      begin
        @(posedge clk_sys) cin[1] <= 1'b0;
        repeat (36) @(posedge clk_sys);
        cin[1] <= 1'b1;
        repeat (36) @(posedge clk_sys);
      end
      h.wr(8'h88, 8'h00);
      h.rd(8'h8b, d, hit);
      `CHK("edge count", 8'h03, d)
    end
    $display("event count test done");
    h.wr(8'h88, 8'h01);
    @(posedge clk_sys) eirq_n <= 2'b10;
    repeat (40) @(posedge clk_sys);
    eirq_n <= 2'b11;
    repeat (40) @(negedge clk_sys);
    `CHK("edge flag", 1'b1, ereq[0])
    @(posedge clk_sys) eack <= 2'b01;
    @(posedge clk_sys) eack <= 2'b00;
    repeat (2) @(negedge clk_sys);
    `CHK("edge flag ack", 1'b0, ereq[0])
    @(posedge clk_sys) eirq_n <= 2'b01;
    repeat (40) @(negedge clk_sys);
    `CHK("level low", 1'b1, ereq[1])
    @(posedge clk_sys) eirq_n <= 2'b11;
    repeat (40) @(negedge clk_sys);
    `CHK("level high", 1'b0, ereq[1])
    $display("external input test done");
    @(posedge clk_sys) rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    h.rd(8'h89, d, hit);
    `CHK("mode after reset", 8'h00, d)
    h.rd(8'h88, d, hit);
    `CHK("control after reset", 8'h00, d)
    $display("reset test done");
    final_report;
  end
endmodule // tb_dual_timer_counter_unit
